//--- hw/haptic_pkg.sv
// constants, register map and carrier types of the haptic mode and calibration control
// Operation
// - Writing 0x07 to mode register leaves standby and selects calibration mode.
// - Writing 0x01 to go register starts calibration; go clears itself on completion.
// - Calibration completion overwrites the result registers with newly computed values; the control writes them only when the run ends without a fault.
// - Linear-resonant-only calibration inputs are ignored while rotating-mass type is selected.
// - Status fault flag tells whether calibration finished without faults.
// - Register contents, including results, persist through standby and enable low.
// - Fuse storage behind 0x16 to 0x1A programs once; later attempts are ignored.
// - Writing 0x01 to 0x1E programs fuses; programmed status then always reads 1.
// - Power cycle or soft reset reloads 0x16 to 0x1A from programmed fuses.
// - Open loop: clamp is full scale, mid-scale is zero, below mid-scale negative.
// - Negative drive reverses a rotating mass, inverts phase of a resonant actuator.
// - Realtime byte is signed two's complement or unsigned per the format bit.
// - Closed loop uses rated level as full scale, never exceeding the clamp.
// - Closed-loop bidirectional treats inputs below mid-scale as zero drive.
// - Closed-loop bidirectional interpretation is the default after power-up.
// - Mode 5 drives continuously at the realtime amplitude, following each update.
// - Mode 3 with analog select set drives from the analog input level.
// - Analog level maps linearly to 0 to 100 percent, half scale at 50 percent.
// - Mode 3 with analog select clear drives from the input pin duty cycle.
package haptic_pkg;
    localparam int DATA_W = 8;
    // register offsets
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MODE = 8'h01;
    localparam logic [7:0] REG_RTP = 8'h02;
    localparam logic [7:0] REG_GO = 8'h0C;
    localparam logic [7:0] REG_RATED = 8'h16;
    localparam logic [7:0] REG_CLAMP = 8'h17;
    localparam logic [7:0] REG_COMP = 8'h18;
    localparam logic [7:0] REG_BEMF = 8'h19;
    localparam logic [7:0] REG_FEEDBACK = 8'h1A;
    localparam logic [7:0] REG_CTRL2 = 8'h1C;
    localparam logic [7:0] REG_CTRL3 = 8'h1D;
    localparam logic [7:0] REG_FUSE = 8'h1E;
    // fuse-backed bank 0x16..0x1A
    localparam int FUSE_WORDS = 5;
    localparam logic [2:0] BANK_RATED = 3'h0;
    localparam logic [2:0] BANK_CLAMP = 3'h1;
    localparam logic [2:0] BANK_COMP = 3'h2;
    localparam logic [2:0] BANK_BEMF = 3'h3;
    localparam logic [2:0] BANK_FEEDBACK = 3'h4;
    // field positions
    localparam int MODE_RESET_BIT = 7;
    localparam int MODE_STANDBY_BIT = 6;
    localparam int STATUS_FAULT_BIT = 3;
    localparam int GO_BIT = 0;
    localparam int FB_TYPE_BIT = 7;
    localparam int CTRL2_BIDIR_BIT = 7;
    localparam int CTRL3_FORMAT_BIT = 3;
    localparam int CTRL3_ANALOG_BIT = 1;
    localparam int CTRL3_OPEN_LOOP_BIT = 0;
    localparam int FUSE_STATUS_BIT = 2;
    localparam int FUSE_PROG_BIT = 0;
    // reset values
    localparam logic [7:0] MODE_RST = 8'h40;
    localparam logic [7:0] RTP_RST = 8'h00;
    localparam logic [7:0] RATED_RST = 8'h3E;
    localparam logic [7:0] CLAMP_RST = 8'h8C;
    localparam logic [7:0] COMP_RST = 8'h0C;
    localparam logic [7:0] BEMF_RST = 8'h6C;
    localparam logic [7:0] FEEDBACK_RST = 8'h36;
    localparam logic [7:0] CTRL2_RST = 8'hF5;
    localparam logic [7:0] CTRL3_RST = 8'hA0;
    localparam logic [7:0] FUSE_RST = 8'h20;
    localparam logic [2:0] DEVICE_ID = 3'h1; // arbitrary identity value
    localparam logic [7:0] MID_SCALE = 8'h80;
    localparam logic [7:0] FULL_SCALE = 8'hFF;
    // timing: one calibration step per duration code increment
    localparam int CLK_HZ = 25_000_000;
    localparam int CAL_STEP_MS = 250;
    localparam int CAL_STEP_CYCLES = CAL_STEP_MS * (CLK_HZ / 1000);
    localparam int PWM_WINDOW = 255;

    typedef enum logic [2:0] {
        MODE_INTERNAL = 3'b000,
        MODE_EDGE = 3'b001,
        MODE_LEVEL = 3'b010,
        MODE_INPUT = 3'b011,
        MODE_AUDIO = 3'b100,
        MODE_REALTIME = 3'b101,
        MODE_DIAG = 3'b110,
        MODE_CALIBRATE = 3'b111
    } mode_e;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RUN = 2'b01,
        CAL_DONE = 2'b10
    } cal_state_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_req_s;

    typedef struct packed {
        logic active;
        logic [7:0] level;
        logic reverse;
        logic phase_invert;
    } drive_s;
endpackage

//--- hw/pwm_duty_meter.sv
// duty-cycle meter for the input pin in pwm mode
`timescale 1ns/1ns
module pwm_duty_meter import haptic_pkg::*; #(
    parameter int WIDTH = DATA_W,
    parameter int WINDOW = PWM_WINDOW
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic pwm_in,
    output logic [WIDTH-1:0] duty
);
    if (WINDOW < 1 || WINDOW > (2 ** WIDTH) - 1) begin : g_bad_window
        $error("pwm window does not fit the duty width");
    end

    logic [WIDTH-1:0] win_cnt;
    logic [WIDTH-1:0] high_cnt;

    // window counter; a window of full-scale cycles makes 100 percent read all ones
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            win_cnt <= '0;
        end else if (win_cnt == WIDTH'(WINDOW - 1)) begin
            win_cnt <= '0;
        end else begin
            win_cnt <= win_cnt + 1'b1;
        end
    end

    // high-time count, sampled into duty at the window end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            high_cnt <= '0;
            duty <= '0;
        end else if (win_cnt == WIDTH'(WINDOW - 1)) begin
            high_cnt <= '0;
            duty <= high_cnt + WIDTH'(pwm_in);
        end else begin
            high_cnt <= high_cnt + WIDTH'(pwm_in);
        end
    end
endmodule

//--- hw/haptic_control.sv
// register file, calibration, fuse store and drive interpretation of the haptic driver
`timescale 1ns/1ns
module haptic_control import haptic_pkg::*; #(
    parameter int STEP_CYCLES = CAL_STEP_CYCLES
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic enable,
    input wire reg_req_s reg_req,
    output logic [7:0] rdata,
    input wire logic input_trigger_pin,
    input wire logic [7:0] analog_level,
    input wire logic fuse_erase,
    output drive_s drive,
    output logic [7:0] drive_ceiling
);
    if (STEP_CYCLES < 1) begin : g_bad_step
        $error("calibration step must be at least one cycle");
    end

    localparam int STEP_W = $clog2(STEP_CYCLES + 1);

    // address inside the fuse-backed bank
    function automatic logic in_bank(input logic [7:0] a);
        return (a >= REG_RATED) && (a <= REG_FEEDBACK);
    endfunction

    function automatic logic [2:0] bank_index(input logic [7:0] a);
        return 3'(a - REG_RATED);
    endfunction

    // doubles a half-scale magnitude, saturating at full scale
    function automatic logic [7:0] sat_double(input logic [7:0] x);
        return (x >= MID_SCALE) ? FULL_SCALE : {x[6:0], 1'b0};
    endfunction

    // fraction x/256 of a reference level
    function automatic logic [7:0] scale(input logic [7:0] x, input logic [7:0] ref_level);
        logic [15:0] prod;
        prod = 16'(x) * 16'(ref_level);
        return prod[15:8];
    endfunction

    logic soft_rst;
    logic do_reset;
    logic reload_pend;
    logic [2:0] mode;
    logic standby;
    logic [7:0] realtime_playback;
    logic [7:0] ctrl2;
    logic [7:0] ctrl3;
    logic [7:4] fuse_cfg;
    logic [7:0] cfg [FUSE_WORDS];
    logic [7:0] fuse_bank [FUSE_WORDS];
    logic fuse_done;
    logic go_flag;
    logic fault;
    cal_state_e cal_state;
    logic [STEP_W-1:0] step_cnt;
    logic [1:0] steps_left;
    logic [7:0] pwm_duty;

    assign do_reset = !nrst || soft_rst;

    logic wr_mode;
    logic fuse_prog_req;
    logic cal_start;
    logic is_lra;
    assign wr_mode = reg_req.wr && reg_req.addr == REG_MODE;
    assign fuse_prog_req = reg_req.wr && reg_req.addr == REG_FUSE && reg_req.data[FUSE_PROG_BIT];
    assign is_lra = cfg[BANK_FEEDBACK][FB_TYPE_BIT];
    assign cal_start = reg_req.wr && reg_req.addr == REG_GO && reg_req.data[GO_BIT]
        && cal_state == CAL_IDLE && mode == MODE_CALIBRATE && !standby && enable;

    // soft reset: one-cycle pulse that resets the whole register file
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= wr_mode && reg_req.data[MODE_RESET_BIT] && !soft_rst;
        end
    end

    // reload request for the cycle after any reset
    always_ff @(posedge ref_clk) begin
        reload_pend <= do_reset;
    end

    // plain control registers; standby gates drive and calibration, contents persist
    always_ff @(posedge ref_clk) begin
        if (do_reset) begin
            mode <= MODE_RST[2:0];
            standby <= MODE_RST[MODE_STANDBY_BIT];
            realtime_playback <= RTP_RST;
            ctrl2 <= CTRL2_RST;
            ctrl3 <= CTRL3_RST;
            fuse_cfg <= FUSE_RST[7:4];
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                REG_MODE: begin
                    mode <= reg_req.data[2:0];
                    standby <= reg_req.data[MODE_STANDBY_BIT];
                end
                REG_RTP: realtime_playback <= reg_req.data;
                REG_CTRL2: ctrl2 <= reg_req.data;
                REG_CTRL3: ctrl3 <= reg_req.data;
                REG_FUSE: fuse_cfg <= reg_req.data[7:4];
                default: ;
            endcase
        end
    end

    // non-volatile store: survives every reset, cleared only by factory erase
    always_ff @(posedge ref_clk) begin
        if (fuse_erase) begin
            fuse_done <= 1'b0;
            for (int i = 0; i < FUSE_WORDS; i++) begin
                fuse_bank[i] <= '0;
            end
        end else if (fuse_prog_req && !fuse_done && !do_reset) begin
            fuse_done <= 1'b1;
            for (int i = 0; i < FUSE_WORDS; i++) begin
                fuse_bank[i] <= cfg[i];
            end
        end
    end

    // calibration results; the erm type zeroes every resonant-only term
    logic [7:0] lra_adj;
    logic [7:0] next_bemf;
    logic [7:0] next_comp;
    logic cal_fault_now;
    always_comb begin
        lra_adj = is_lra ? {2'b00, ctrl2[5:0]} : 8'h00;
        next_bemf = 8'(cfg[BANK_CLAMP] - cfg[BANK_RATED] + lra_adj);
        next_comp = 8'(COMP_RST + {5'b0, cfg[BANK_FEEDBACK][6:4]});
        cal_fault_now = cfg[BANK_RATED] == 8'h00 || cfg[BANK_RATED] > cfg[BANK_CLAMP]
            || standby || !enable;
    end

    // fuse-backed bank: reset defaults, then reload, then writes and results
    always_ff @(posedge ref_clk) begin
        if (do_reset) begin
            cfg[BANK_RATED] <= RATED_RST;
            cfg[BANK_CLAMP] <= CLAMP_RST;
            cfg[BANK_COMP] <= COMP_RST;
            cfg[BANK_BEMF] <= BEMF_RST;
            cfg[BANK_FEEDBACK] <= FEEDBACK_RST;
        end else if (reload_pend && fuse_done) begin
            for (int i = 0; i < FUSE_WORDS; i++) begin
                cfg[i] <= fuse_bank[i];
            end
        end else begin
            if (reg_req.wr && in_bank(reg_req.addr)) begin
                cfg[bank_index(reg_req.addr)] <= reg_req.data;
            end
            // results written last so they win over a same-cycle write
            if (cal_state == CAL_DONE && !cal_fault_now) begin
                cfg[BANK_COMP] <= next_comp;
                cfg[BANK_BEMF] <= next_bemf;
                cfg[BANK_FEEDBACK][1:0] <= cfg[BANK_FEEDBACK][3:2];
            end
        end
    end

    // calibration sequencer: duration code + 1 steps
    always_ff @(posedge ref_clk) begin
        if (do_reset) begin
            cal_state <= CAL_IDLE;
            step_cnt <= '0;
            steps_left <= '0;
        end else begin
            case (cal_state)
                CAL_IDLE: begin
                    if (cal_start) begin
                        cal_state <= CAL_RUN;
                        step_cnt <= STEP_W'(STEP_CYCLES - 1);
                        steps_left <= fuse_cfg[5:4];
                    end
                end
                CAL_RUN: begin
                    // dropping to standby or enable low cuts the run short as a fault
                    if (standby || !enable) begin
                        cal_state <= CAL_DONE;
                    end else if (step_cnt != '0) begin
                        step_cnt <= step_cnt - 1'b1;
                    end else if (steps_left != 2'b00) begin
                        step_cnt <= STEP_W'(STEP_CYCLES - 1);
                        steps_left <= steps_left - 1'b1;
                    end else begin
                        cal_state <= CAL_DONE;
                    end
                end
                CAL_DONE: cal_state <= CAL_IDLE;
                default: cal_state <= CAL_IDLE;
            endcase
        end
    end

    // go flag: high from launch through the done cycle, then self-clears
    always_ff @(posedge ref_clk) begin
        if (do_reset) begin
            go_flag <= 1'b0;
        end else if (cal_start) begin
            go_flag <= 1'b1;
        end else if (cal_state == CAL_DONE) begin
            go_flag <= 1'b0;
        end
    end

    // fault flag holds the outcome of the last calibration
    always_ff @(posedge ref_clk) begin
        if (do_reset) begin
            fault <= 1'b0;
        end else if (cal_state == CAL_DONE) begin
            fault <= cal_fault_now;
        end
    end

    // read data, one cycle after the read strobe; unmapped offsets read zero
    logic [7:0] next_rdata;
    always_comb begin
        case (reg_req.addr)
            REG_STATUS: next_rdata = {DEVICE_ID, 1'b0, fault, 3'b000};
            REG_MODE: next_rdata = {1'b0, standby, 3'b000, mode};
            REG_RTP: next_rdata = realtime_playback;
            REG_GO: next_rdata = {7'h00, go_flag};
            REG_CTRL2: next_rdata = ctrl2;
            REG_CTRL3: next_rdata = ctrl3;
            REG_FUSE: next_rdata = {fuse_cfg, 1'b0, fuse_done, 2'b00};
            default: next_rdata = in_bank(reg_req.addr) ? cfg[bank_index(reg_req.addr)] : 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (do_reset) begin
            rdata <= 8'h00;
        end else if (reg_req.rd) begin
            rdata <= next_rdata;
        end
    end

    pwm_duty_meter #(
        .WIDTH(DATA_W),
        .WINDOW(PWM_WINDOW)
    ) u_duty (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pwm_in(input_trigger_pin),
        .duty(pwm_duty)
    );

    // source selection and data-format interpretation
    logic [7:0] src;
    logic [7:0] u;
    logic neg;
    logic [7:0] mag;
    logic [7:0] lvl;
    drive_s next_drive;
    always_comb begin
        // analog code 0..255 spans 0..100 percent, half scale at code 0x80
        if (mode == MODE_REALTIME) begin
            src = realtime_playback;
        end else if (ctrl3[CTRL3_ANALOG_BIT]) begin
            src = analog_level;
        end else begin
            src = pwm_duty;
        end
        // signed realtime data moves to offset binary so mid-scale means zero
        u = (mode == MODE_REALTIME && !ctrl3[CTRL3_FORMAT_BIT]) ? (src ^ MID_SCALE) : src;
        neg = 1'b0;
        mag = 8'h00;
        lvl = 8'h00;
        if (ctrl3[CTRL3_OPEN_LOOP_BIT]) begin
            neg = u < MID_SCALE;
            mag = neg ? 8'(MID_SCALE - u) : 8'(u - MID_SCALE);
            lvl = scale(sat_double(mag), cfg[BANK_CLAMP]);
        end else if (ctrl2[CTRL2_BIDIR_BIT]) begin
            mag = (u > MID_SCALE) ? 8'(u - MID_SCALE) : 8'h00;
            lvl = scale(sat_double(mag), cfg[BANK_RATED]);
        end else begin
            lvl = scale(u, cfg[BANK_RATED]);
        end
        // clamp has priority over the rated level
        if (lvl > cfg[BANK_CLAMP]) begin
            lvl = cfg[BANK_CLAMP];
        end
        next_drive.active = enable && !standby && cal_state == CAL_IDLE
            && (mode == MODE_REALTIME || mode == MODE_INPUT);
        next_drive.level = next_drive.active ? lvl : 8'h00;
        next_drive.reverse = next_drive.active && neg && !is_lra;
        next_drive.phase_invert = next_drive.active && neg && is_lra;
    end

    // drive outputs registered, so an amplitude write shows one cycle later
    always_ff @(posedge ref_clk) begin
        if (do_reset) begin
            drive <= '0;
            drive_ceiling <= CLAMP_RST;
        end else begin
            drive <= next_drive;
            drive_ceiling <= cfg[BANK_CLAMP];
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (do_reset);

    sequence cal_launch;
        cal_start;
    endsequence

    sequence cal_finish;
        cal_state == CAL_DONE;
    endsequence

    chk_cal_launch: assert property (cal_launch |=> go_flag && cal_state == CAL_RUN)
        else $error("calibration did not start on go");
    chk_go_clears: assert property (cal_finish |=> !go_flag)
        else $error("go bit not cleared after calibration");
    chk_go_busy: assert property (cal_state == CAL_RUN |-> go_flag)
        else $error("go bit low while calibrating");
    chk_result_write: assert property ((cal_finish and !cal_fault_now)
        |=> cfg[BANK_BEMF] == $past(next_bemf) && cfg[BANK_COMP] == $past(next_comp))
        else $error("calibration results not written");
    chk_erm_ignore: assert property ((cal_finish and !cal_fault_now && !is_lra)
        |=> cfg[BANK_BEMF] == 8'($past(cfg[BANK_CLAMP]) - $past(cfg[BANK_RATED])))
        else $error("resonant-only input affected rotating-mass result");
    chk_fault_flag: assert property (cal_finish |=> fault == $past(cal_fault_now))
        else $error("fault flag does not match calibration outcome");
    chk_fuse_once: assert property (fuse_done && fuse_prog_req && !fuse_erase
        |=> $stable(fuse_bank[BANK_RATED]) && $stable(fuse_bank[BANK_CLAMP]))
        else $error("fuse store changed after first programming");
    chk_fuse_status: assert property (reg_req.rd && reg_req.addr == REG_FUSE && fuse_done
        |=> rdata[FUSE_STATUS_BIT])
        else $error("programmed status did not read one");
    chk_fuse_reload: assert property (reload_pend && fuse_done && !fuse_erase
        |=> cfg[BANK_CLAMP] == fuse_bank[BANK_CLAMP])
        else $error("bank not reloaded from fuses");
    chk_drive_ceiling: assert property (drive.level <= drive_ceiling)
        else $error("drive level above clamp");
    chk_bidir_floor: assert property (next_drive.active && !ctrl3[CTRL3_OPEN_LOOP_BIT]
        && ctrl2[CTRL2_BIDIR_BIT] && u <= MID_SCALE |=> drive.level == 8'h00)
        else $error("bidirectional drive below mid-scale not zero");
    chk_open_reverse: assert property (next_drive.active && ctrl3[CTRL3_OPEN_LOOP_BIT]
        && u < MID_SCALE |=> (drive.reverse != drive.phase_invert))
        else $error("negative open-loop drive not applied");
endmodule

//--- tb/host_model.sv
// host processor model issuing single-byte register requests
`timescale 1ns/1ns
module host_model import haptic_pkg::*; (
    input wire logic ref_clk,
    output reg_req_s reg_req,
    input wire logic [7:0] rdata
);
    initial begin
        reg_req = '0;
    end
    // one-cycle strobe; released data is inverted so a stale byte is never seen
    task automatic issue(input logic w, input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        #1;
        reg_req = '{wr: w, rd: !w, addr: addr, data: data};
        @(posedge ref_clk);
        #1;
        reg_req.wr = 1'b0;
        reg_req.rd = 1'b0;
        reg_req.data = ~data;
    endtask
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        issue(1'b1, addr, data);
    endtask
    // rdata is registered at the taking edge, so it is read just after it
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        issue(1'b0, addr, 8'h00);
        data = rdata;
    endtask
    // recommended duration code with the program bit clear, then leave standby in
    // calibration mode, go is refused otherwise
    task automatic start_cal;
        write_reg(REG_FUSE, 8'h30);
        write_reg(REG_MODE, 8'h07);
        write_reg(REG_GO, 8'h01);
    endtask
endmodule

//--- tb/tb_top.sv
// self-checking bench of the haptic mode and calibration control
`timescale 1ns/1ns
module tb_top import haptic_pkg::*; ;
    typedef struct packed {
        logic [7:0] fb;
        logic [7:0] c3;
        logic [7:0] md;
        logic [7:0] src;
        logic [7:0] ana;
        drive_s exp;
    } row_s;
    logic ref_clk, nrst, enable, fuse_erase, input_trigger_pin;
    logic [7:0] analog_level, rdata, drive_ceiling;
    reg_req_s reg_req;
    drive_s drive;
    int err_count, checks_done, cycles;
    row_s rows [7];
    logic [15:0] rv [9];

    haptic_control #(.STEP_CYCLES(4)) DUT (.ref_clk(ref_clk), .nrst(nrst), .enable(enable),
        .reg_req(reg_req), .rdata(rdata), .input_trigger_pin(input_trigger_pin),
        .analog_level(analog_level), .fuse_erase(fuse_erase), .drive(drive),
        .drive_ceiling(drive_ceiling));
    host_model host (.ref_clk(ref_clk), .reg_req(reg_req), .rdata(rdata));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // hang guard: the whole run needs under a thousand cycles, mostly duty windows
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            close_out();
        end
    end

    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_drive(input drive_s exp, input drive_s got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value drive expected %h seen %h", exp, got);
        end
    endtask
    task automatic chk_reg(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] got;
        host.read_reg(addr, got);
        cmp_byte($sformatf("reg %h", addr), exp, got);
    endtask
    task automatic hw_reset;
        @(posedge ref_clk);
        #1;
        nrst = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        {nrst, enable, input_trigger_pin, analog_level} = '0;
        fuse_erase = 1'b1;
        rv = '{{REG_MODE, MODE_RST}, {REG_RTP, 8'h00}, {REG_GO, 8'h00}, {REG_RATED, RATED_RST},
            {REG_CLAMP, CLAMP_RST}, {REG_CTRL2, CTRL2_RST}, {REG_CTRL3, CTRL3_RST},
            {REG_FUSE, FUSE_RST}, {8'h30, 8'h00}};
        // feedback, input control, mode, realtime byte, analog level, expected drive
        rows = '{'{8'h36, 8'hA0, 8'h05, 8'h7F, 8'h00, '{1'b1, 8'h3D, 1'b0, 1'b0}},
            '{8'h36, 8'hA0, 8'h05, 8'h80, 8'h00, '{1'b1, 8'h00, 1'b0, 1'b0}},
            '{8'h36, 8'hA9, 8'h05, 8'h00, 8'h00, '{1'b1, 8'h8B, 1'b1, 1'b0}},
            '{8'hB6, 8'hA9, 8'h05, 8'h00, 8'h00, '{1'b1, 8'h8B, 1'b0, 1'b1}},
            '{8'h36, 8'hA9, 8'h05, 8'hFF, 8'h00, '{1'b1, 8'h8A, 1'b0, 1'b0}},
            '{8'h36, 8'hAB, 8'h03, 8'h00, 8'hC0, '{1'b1, 8'h46, 1'b0, 1'b0}},
            '{8'h36, 8'hA0, 8'h40, 8'h7F, 8'h00, '{1'b0, 8'h00, 1'b0, 1'b0}}};
        hw_reset();
        fuse_erase = 1'b0;
        enable = 1'b1;
        cmp_byte("ceiling", CLAMP_RST, drive_ceiling);
        chk_reg(REG_STATUS, {DEVICE_ID, 5'h00});
        for (int i = 0; i < 9; i++) chk_reg(rv[i][15:8], rv[i][7:0]);
        // ordinary drive cases
        for (int i = 0; i < 7; i++) begin
            analog_level = rows[i].ana;
            host.write_reg(REG_FEEDBACK, rows[i].fb);
            host.write_reg(REG_CTRL3, rows[i].c3);
            host.write_reg(REG_RTP, rows[i].src);
            host.write_reg(REG_MODE, rows[i].md);
            repeat (3) @(posedge ref_clk);
            #1;
            cmp_drive(rows[i].exp, drive);
        end
        // closed-loop unidirectional with unsigned realtime data, then pwm at full duty
        host.write_reg(REG_CTRL2, 8'h75);
        host.write_reg(REG_CTRL3, 8'hA8);
        host.write_reg(REG_RTP, 8'h80);
        host.write_reg(REG_MODE, 8'h05);
        repeat (3) @(posedge ref_clk);
        #1;
        cmp_drive(drive_s'{1'b1, 8'h1F, 1'b0, 1'b0}, drive);
        input_trigger_pin = 1'b1;
        host.write_reg(REG_MODE, 8'h03);
        // duty windows are not aligned to the pin, so wait until a whole one is measured
        repeat (2 * PWM_WINDOW + 10) @(posedge ref_clk);
        #1;
        cmp_drive(drive_s'{1'b1, 8'h3D, 1'b0, 1'b0}, drive);
        // calibration: 4 steps of 4 cycles with the recommended duration code
        host.start_cal();
        chk_reg(REG_GO, 8'h01);
        repeat (20) @(posedge ref_clk);
        chk_reg(REG_GO, 8'h00);
        chk_reg(REG_STATUS, {DEVICE_ID, 5'h00});
        chk_reg(REG_COMP, 8'h0F);
        chk_reg(REG_BEMF, 8'h4E);
        chk_reg(REG_FEEDBACK, 8'h35);
        // enable dropped mid-run cuts the calibration short with a fault
        host.start_cal();
        enable = 1'b0;
        repeat (3) @(posedge ref_clk);
        chk_reg(REG_STATUS, {DEVICE_ID, 5'h08});
        chk_reg(REG_GO, 8'h00);
        // results must survive enable low and standby
        enable = 1'b0;
        host.write_reg(REG_MODE, MODE_RST);
        chk_reg(REG_BEMF, 8'h4E);
        enable = 1'b1;
        // fuse store: program once, reload on soft and hard reset, refuse a second time
        host.write_reg(REG_RATED, 8'h55);
        host.write_reg(REG_FUSE, 8'h01);
        chk_reg(REG_FUSE, 8'h04);
        host.write_reg(REG_RATED, 8'h11);
        host.write_reg(REG_MODE, 8'h80);
        repeat (3) @(posedge ref_clk);
        chk_reg(REG_RATED, 8'h55);
        chk_reg(REG_FEEDBACK, 8'h35);
        host.write_reg(REG_RATED, 8'h22);
        host.write_reg(REG_FUSE, 8'h01);
        hw_reset();
        chk_reg(REG_RATED, 8'h55);
        chk_reg(REG_FUSE, 8'h24);
        close_out();
    end
endmodule
